// *** core/ccc_pkg.sv ***
// package: register map, field layout and codes
`default_nettype none

package ccc_pkg;

  // bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W  = 16;
  localparam int CNT_W  = 16;
  localparam int NPIN   = 3;   // ch1 input, input three, input four

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_MODE34      = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_ENABLE      = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_CH1_CAPTURE = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_CH12_DIR    = 8'h40;

  // values after reset
  localparam logic [REG_W-1:0] RST_MODE34  = 16'h0000;
  localparam logic [REG_W-1:0] RST_ENABLE  = 16'h0000;
  localparam logic [REG_W-1:0] RST_CAPTURE = 16'h0000;
  localparam logic [REG_W-1:0] RST_DIR     = 16'h0000;

  // mode field positions
  localparam int M_CH3_DIR_LSB  = 0;
  localparam int M_CH3_PSC_LSB  = 2;
  localparam int M_CH3_FILT_LSB = 4;
  localparam int M_CH4_DIR_LSB  = 8;
  localparam int M_CH4_PSC_LSB  = 10;
  localparam int M_CH4_FILT_LSB = 12;

  // ch1/ch2 direction field positions
  localparam int D_CH1_LSB = 0;
  localparam int D_CH2_LSB = 8;

  // enable register: one nibble per channel
  localparam int E_STRIDE = 4;
  localparam int E_EN     = 0;
  localparam int E_POL    = 1;
  localparam int E_NPOL   = 3;
  localparam logic [REG_W-1:0] EN_WRITABLE = 16'hbbbb;  // bits 2, 6, 10, 14 read zero

  // direction select codes
  typedef enum logic [1:0] {
    DIR_OUTPUT     = 2'b00,
    DIR_INPUT_OWN  = 2'b01,
    DIR_INPUT_PAIR = 2'b10,
    DIR_INPUT_TRIG = 2'b11
  } ccc_dir_e;

  // input polarity codes {complement, polarity}
  localparam logic [1:0] POL_RISE = 2'b00;
  localparam logic [1:0] POL_FALL = 2'b01;
  localparam logic [1:0] POL_RSVD = 2'b10;
  localparam logic [1:0] POL_BOTH = 2'b11;

  // prescaler terminal count per code
  localparam logic [2:0] PSC_LAST_DIV1 = 3'h0;
  localparam logic [2:0] PSC_LAST_DIV2 = 3'h1;
  localparam logic [2:0] PSC_LAST_DIV4 = 3'h3;
  localparam logic [2:0] PSC_LAST_DIV8 = 3'h7;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : ccc_pkg

`default_nettype wire

// *** core/ccc_capture_prescale.sv ***
// module: capture event prescaler
`default_nettype none

module ccc_capture_prescale (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       capture_enable,
  input  wire logic       input_event,
  input  wire logic [1:0] prescale_code,
  output var  logic       capture_pulse
);

  typedef struct packed {
    logic [2:0] count;
    logic       pulse;
  } ccc_psc_s;

  ccc_psc_s   state_reg;
  ccc_psc_s   state_next;
  logic [2:0] last_count;

  // terminal count for the chosen factor
  always_comb begin
    unique case (prescale_code)
      2'b00: last_count = ccc_pkg::PSC_LAST_DIV1;
      2'b01: last_count = ccc_pkg::PSC_LAST_DIV2;
      2'b10: last_count = ccc_pkg::PSC_LAST_DIV4;
      2'b11: last_count = ccc_pkg::PSC_LAST_DIV8;
    endcase
  end

  // count events, restart while disabled
  always_comb begin
    state_next       = state_reg;
    state_next.pulse = 1'b0;
    if (!capture_enable) begin
      state_next.count = 3'h0;  // [R16]
    end else if (input_event) begin
      if (state_reg.count >= last_count) begin
        state_next.count = 3'h0;  // [R3]
        state_next.pulse = 1'b1;
      end else begin
        state_next.count = state_reg.count + 3'h1;  // [R16]
      end
    end
  end

  // state register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign capture_pulse = state_reg.pulse;

endmodule : ccc_capture_prescale

`default_nettype wire

// *** core/ccc_capture_channel_config.sv ***
// module: channel configuration, register slave and ch1 capture
//
// How it works
// [R1] ch3 select: 00 out, input three/four/trigger
// [R2] selects change only while channel disabled
// [R3] ch3 prescale captures every 1/2/4/8 events
// [R4] ch4 select: 00 out, input four/three/trigger
// [R5] filter and prescale fields at fixed bits
// [R6] ch1 enable bit gates the output
// [R7] ch1 enable bit gates counter capture
// [R8] ch1 polarity bit: active high or low
// [R9] input code 00: non-inverted, rising edge
// [R10] input code 01: inverted, falling edge
// [R11] enable register at 0x20, resets zero
// [R12] code 11 both edges; complement cleared on output
// [R13] channels 2-4 repeat bits per nibble
// [R14] disabled output low, drive enable low
// [R15] select write ignored while channel enabled
// [R16] prescaler counts only while capture enabled
//
// Design decision made here: the AXI4-Lite interface to the registers.
`default_nettype none

module ccc_capture_channel_config (
  input  wire logic                        clk_sys,
  input  wire logic                        sys_rst,
  // register bus
  input  wire logic [ccc_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output var  logic                        s_axi_awready,
  input  wire logic [ccc_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output var  logic                        s_axi_wready,
  output var  logic [1:0]                  s_axi_bresp,
  output var  logic                        s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [ccc_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output var  logic                        s_axi_arready,
  output var  logic [ccc_pkg::DATA_W-1:0]  s_axi_rdata,
  output var  logic [1:0]                  s_axi_rresp,
  output var  logic                        s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // channel inputs
  input  wire logic                        filtered_channel_input,
  input  wire logic                        timer_input_three,
  input  wire logic                        timer_input_four,
  input  wire logic                        trigger_select_signal,
  input  wire logic [ccc_pkg::CNT_W-1:0]   counter_value,
  input  wire logic [3:0]                  channel_reference_output,
  // channel outputs
  output var  logic [3:0]                  channel_output,
  output var  logic [3:0]                  channel_output_drive_enable,
  output var  logic                        ch3_capture_strobe,
  output var  logic                        ch4_capture_strobe,
  output var  logic [3:0]                  ch3_input_filter,
  output var  logic [3:0]                  ch4_input_filter
);

  typedef struct packed {
    // registers
    logic [ccc_pkg::REG_W-1:0]  mode34;
    logic [ccc_pkg::REG_W-1:0]  enable;
    logic [ccc_pkg::REG_W-1:0]  dir12;
    logic [ccc_pkg::CNT_W-1:0]  ch1_capture_value;
    // pin synchronisers and settled levels
    logic [ccc_pkg::NPIN-1:0]   sync1;
    logic [ccc_pkg::NPIN-1:0]   sync2;
    logic [ccc_pkg::NPIN-1:0]   sync3;
    logic [ccc_pkg::NPIN-1:0]   pin_level;
    logic [2:0]                 prev_sel;   // ch4, ch3, ch1 selected levels
    // channel outputs
    logic [3:0]                 chan_out;
    logic [3:0]                 chan_drive;
    // write side of the bus
    logic                       aw_have;
    logic [ccc_pkg::ADDR_W-1:0] aw_addr;
    logic                       w_have;
    logic [ccc_pkg::DATA_W-1:0] w_data;
    logic [3:0]                 w_strb;
    logic                       awready;
    logic                       wready;
    logic                       bvalid;
    logic [1:0]                 bresp;
    // read side of the bus
    logic                       arready;
    logic                       rvalid;
    logic [ccc_pkg::DATA_W-1:0] rdata;
    logic [1:0]                 rresp;
  } ccc_state_s;

  ccc_state_s state_reg;
  ccc_state_s state_next;

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old_val,
                                          input logic [31:0] wdata,
                                          input logic [3:0]  wstrb);
    logic [15:0] v;
    v = old_val;
    if (wstrb[0]) v[7:0] = wdata[7:0];
    if (wstrb[1]) v[15:8] = wdata[15:8];
    return v;
  endfunction

  // word decode of a byte address
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    return addr[7:2] == ofs[7:2];
  endfunction

  // edge qualified by input polarity
  function automatic logic pol_edge(input logic [1:0] code,
                                    input logic       cur,
                                    input logic       prev);
    logic inv;
    inv = (code == ccc_pkg::POL_FALL);  // [R10]
    if (code == ccc_pkg::POL_BOTH) return cur != prev;  // [R12]
    return (cur ^ inv) & ~(prev ^ inv);  // [R9]
  endfunction

  // complement polarity cleared on output channels
  function automatic logic [15:0] clear_npol(input logic [15:0] v,
                                             input logic [7:0]  dirs);
    logic [15:0] r;
    r = v & ccc_pkg::EN_WRITABLE;  // [R13]
    for (int ch = 0; ch < 4; ch++) begin
      if (dirs[ch*2 +: 2] == ccc_pkg::DIR_OUTPUT) begin
        r[ch*ccc_pkg::E_STRIDE + ccc_pkg::E_NPOL] = 1'b0;   // [R12]
      end
    end
    return r;
  endfunction

  // live register fields
  logic [7:0] dirs_live;
  logic [1:0] dir_ch1;
  logic [1:0] dir_ch2;
  logic [1:0] dir_ch3;
  logic [1:0] dir_ch4;
  logic [3:0] en_bit;
  logic [3:0] pol_bit;
  logic [3:0] npol_bit;
  logic       sel_ch1;
  logic       sel_ch3;
  logic       sel_ch4;
  logic       edge_ch1;
  logic       edge_ch3;
  logic       edge_ch4;
  logic       armed_ch3;
  logic       armed_ch4;

  assign dir_ch1 = state_reg.dir12[ccc_pkg::D_CH1_LSB +: 2];
  assign dir_ch2 = state_reg.dir12[ccc_pkg::D_CH2_LSB +: 2];
  assign dir_ch3 = state_reg.mode34[ccc_pkg::M_CH3_DIR_LSB +: 2];
  assign dir_ch4 = state_reg.mode34[ccc_pkg::M_CH4_DIR_LSB +: 2];
  assign dirs_live = {dir_ch4, dir_ch3, dir_ch2, dir_ch1};

  // per-channel enable and polarity bits
  always_comb begin
    for (int ch = 0; ch < 4; ch++) begin
      en_bit[ch]   = state_reg.enable[ch*ccc_pkg::E_STRIDE + ccc_pkg::E_EN];   // [R13]
      pol_bit[ch]  = state_reg.enable[ch*ccc_pkg::E_STRIDE + ccc_pkg::E_POL];
      npol_bit[ch] = state_reg.enable[ch*ccc_pkg::E_STRIDE + ccc_pkg::E_NPOL];
    end
  end

  // capture source selection
  always_comb begin
    sel_ch1 = state_reg.pin_level[0];
    unique case (dir_ch3)
      ccc_pkg::DIR_INPUT_OWN:  sel_ch3 = state_reg.pin_level[1];  // [R1]
      ccc_pkg::DIR_INPUT_PAIR: sel_ch3 = state_reg.pin_level[2];  // [R1]
      ccc_pkg::DIR_INPUT_TRIG: sel_ch3 = trigger_select_signal;  // [R1]
      default:                 sel_ch3 = 1'b0;
    endcase
    unique case (dir_ch4)
      ccc_pkg::DIR_INPUT_OWN:  sel_ch4 = state_reg.pin_level[2];  // [R4]
      ccc_pkg::DIR_INPUT_PAIR: sel_ch4 = state_reg.pin_level[1];  // [R4]
      ccc_pkg::DIR_INPUT_TRIG: sel_ch4 = trigger_select_signal;  // [R4]
      default:                 sel_ch4 = 1'b0;
    endcase
  end

  // edges and capture arming
  assign edge_ch1  = pol_edge({npol_bit[0], pol_bit[0]}, sel_ch1, state_reg.prev_sel[0]);
  assign edge_ch3  = pol_edge({npol_bit[2], pol_bit[2]}, sel_ch3, state_reg.prev_sel[1]);
  assign edge_ch4  = pol_edge({npol_bit[3], pol_bit[3]}, sel_ch4, state_reg.prev_sel[2]);
  assign armed_ch3 = en_bit[2] && (dir_ch3 != ccc_pkg::DIR_OUTPUT);  // [R16]
  assign armed_ch4 = en_bit[3] && (dir_ch4 != ccc_pkg::DIR_OUTPUT);  // [R16]

  // channel 3 prescaler
  ccc_capture_prescale u_psc_ch3 (
    .clk_sys        (clk_sys),
    .sys_rst        (sys_rst),
    .capture_enable (armed_ch3),
    .input_event    (edge_ch3),
    .prescale_code  (state_reg.mode34[ccc_pkg::M_CH3_PSC_LSB +: 2]),  // [R3]
    .capture_pulse  (ch3_capture_strobe)
  );

  // channel 4 prescaler
  ccc_capture_prescale u_psc_ch4 (
    .clk_sys        (clk_sys),
    .sys_rst        (sys_rst),
    .capture_enable (armed_ch4),
    .input_event    (edge_ch4),
    .prescale_code  (state_reg.mode34[ccc_pkg::M_CH4_PSC_LSB +: 2]),  // [R5]
    .capture_pulse  (ch4_capture_strobe)
  );

  // next state
  always_comb begin
    logic [15:0] wv;
    logic [7:0]  dirs;
    wv         = '0;
    dirs       = '0;
    state_next = state_reg;

    // three-flop synchroniser, level once stages agree
    state_next.sync1 = {timer_input_four, timer_input_three, filtered_channel_input};
    state_next.sync2 = state_reg.sync1;
    state_next.sync3 = state_reg.sync2;
    for (int i = 0; i < ccc_pkg::NPIN; i++) begin
      if (state_reg.sync2[i] == state_reg.sync3[i]) begin
        state_next.pin_level[i] = state_reg.sync3[i];
      end
    end
    state_next.prev_sel = {sel_ch4, sel_ch3, sel_ch1};

    // ch1 counter capture
    if (dir_ch1 != ccc_pkg::DIR_OUTPUT && en_bit[0] && edge_ch1) begin
      state_next.ch1_capture_value = counter_value;  // [R7]
    end

    // output stage of output-mode channels
    for (int ch = 0; ch < 4; ch++) begin
      if (dirs_live[ch*2 +: 2] == ccc_pkg::DIR_OUTPUT && en_bit[ch]) begin
        state_next.chan_out[ch]   = channel_reference_output[ch] ^ pol_bit[ch];  // [R8]
        state_next.chan_drive[ch] = 1'b1;  // [R14]
      end else begin
        state_next.chan_out[ch]   = 1'b0;  // [R6]
        state_next.chan_drive[ch] = 1'b0;  // [R14]
      end
    end

    // address and data taken apart
    if (s_axi_awvalid && state_reg.awready) begin
      state_next.aw_have = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && state_reg.wready) begin
      state_next.w_have = 1'b1;
      state_next.w_data = s_axi_wdata;
      state_next.w_strb = s_axi_wstrb;
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end

    // write once both halves held
    if (state_next.aw_have && state_next.w_have && !state_next.bvalid) begin
      state_next.aw_have = 1'b0;
      state_next.w_have  = 1'b0;
      state_next.bvalid  = 1'b1;
      state_next.bresp   = ccc_pkg::RESP_OKAY;
      if (hit(state_next.aw_addr, ccc_pkg::OFS_MODE34)) begin
        wv = merge16(state_reg.mode34, state_next.w_data, state_next.w_strb);
        if (en_bit[2]) begin
          wv[ccc_pkg::M_CH3_DIR_LSB +: 2] = dir_ch3;  // [R15]
        end
        if (en_bit[3]) begin
          wv[ccc_pkg::M_CH4_DIR_LSB +: 2] = dir_ch4;  // [R15]
        end
        state_next.mode34 = wv;  // [R5]
      end else if (hit(state_next.aw_addr, ccc_pkg::OFS_ENABLE)) begin
        state_next.enable = merge16(state_reg.enable, state_next.w_data,
                                    state_next.w_strb);  // [R11]
      end else if (hit(state_next.aw_addr, ccc_pkg::OFS_CH12_DIR)) begin
        wv = merge16(state_reg.dir12, state_next.w_data, state_next.w_strb);
        wv = wv & 16'h0303;
        if (en_bit[0]) begin
          wv[ccc_pkg::D_CH1_LSB +: 2] = dir_ch1;  // [R15]
        end
        if (en_bit[1]) begin
          wv[ccc_pkg::D_CH2_LSB +: 2] = dir_ch2;  // [R15]
        end
        state_next.dir12 = wv;
      end else if (!hit(state_next.aw_addr, ccc_pkg::OFS_CH1_CAPTURE)) begin
        state_next.bresp = ccc_pkg::RESP_SLVERR;  // unmapped word
      end
    end

    // complement polarity follows directions
    dirs = {state_next.mode34[ccc_pkg::M_CH4_DIR_LSB +: 2],
            state_next.mode34[ccc_pkg::M_CH3_DIR_LSB +: 2],
            state_next.dir12[ccc_pkg::D_CH2_LSB +: 2],
            state_next.dir12[ccc_pkg::D_CH1_LSB +: 2]};
    state_next.enable = clear_npol(state_next.enable, dirs);  // [R12]

    // read channel
    if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && state_reg.arready) begin
      state_next.rvalid = 1'b1;
      state_next.rresp  = ccc_pkg::RESP_OKAY;
      if (hit(s_axi_araddr, ccc_pkg::OFS_MODE34)) begin
        state_next.rdata = {16'h0000, state_reg.mode34};
      end else if (hit(s_axi_araddr, ccc_pkg::OFS_ENABLE)) begin
        state_next.rdata = {16'h0000, state_reg.enable};
      end else if (hit(s_axi_araddr, ccc_pkg::OFS_CH1_CAPTURE)) begin
        state_next.rdata = {16'h0000, state_reg.ch1_capture_value};
      end else if (hit(s_axi_araddr, ccc_pkg::OFS_CH12_DIR)) begin
        state_next.rdata = {16'h0000, state_reg.dir12};
      end else begin
        state_next.rdata = 32'h0000_0000;
        state_next.rresp = ccc_pkg::RESP_SLVERR;
      end
    end

    // ready flags from the holding state
    state_next.awready = !state_next.aw_have && !state_next.bvalid;
    state_next.wready  = !state_next.w_have && !state_next.bvalid;
    state_next.arready = !state_next.rvalid;
  end

  // state register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg                   <= '0;
      state_reg.mode34            <= ccc_pkg::RST_MODE34;
      state_reg.enable            <= ccc_pkg::RST_ENABLE;  // [R11]
      state_reg.dir12             <= ccc_pkg::RST_DIR;
      state_reg.ch1_capture_value <= ccc_pkg::RST_CAPTURE;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs from the state register
  assign s_axi_awready               = state_reg.awready;
  assign s_axi_wready                = state_reg.wready;
  assign s_axi_bvalid                = state_reg.bvalid;
  assign s_axi_bresp                 = state_reg.bresp;
  assign s_axi_arready               = state_reg.arready;
  assign s_axi_rvalid                = state_reg.rvalid;
  assign s_axi_rdata                 = state_reg.rdata;
  assign s_axi_rresp                 = state_reg.rresp;
  assign channel_output              = state_reg.chan_out;
  assign channel_output_drive_enable = state_reg.chan_drive;
  assign ch3_input_filter            = state_reg.mode34[ccc_pkg::M_CH3_FILT_LSB +: 4];  // [R5]
  assign ch4_input_filter            = state_reg.mode34[ccc_pkg::M_CH4_FILT_LSB +: 4];  // [R5]

endmodule : ccc_capture_channel_config

`default_nettype wire

// *** bench/ccc_checker.sv ***
// checker: bus timing and channel output relations
`default_nettype none

module ccc_checker (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [3:0]  channel_reference_output,
  input wire logic [3:0]  channel_output,
  input wire logic [3:0]  channel_output_drive_enable,
  input wire logic        ch3_capture_strobe,
  input wire logic        ch4_capture_strobe,
  input wire logic [3:0]  ch3_input_filter,
  input wire logic [3:0]  ch4_input_filter
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic ar_en;
  logic ar_mode;
  logic en_wr;
  // accepted enable and mode reads
  assign ar_en = s_axi_arvalid && s_axi_arready && s_axi_araddr == ccc_pkg::OFS_ENABLE;
  assign ar_mode = s_axi_arvalid && s_axi_arready && s_axi_araddr == ccc_pkg::OFS_MODE34;
  // enable written since reset
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) en_wr <= 1'b0;
    else if (s_axi_awvalid && s_axi_awready && s_axi_awaddr == ccc_pkg::OFS_ENABLE) en_wr <= 1'b1;
  end
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> s_axi_bvalid) else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##1
    s_axi_rvalid && !s_axi_arready) else $error("read data late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  a_enable_reset: assert property (ar_en && !en_wr |=> s_axi_rdata == 32'h0)
    else $error("enable not zero");
  a_enable_rsvd: assert property (ar_en |=> (s_axi_rdata & 32'hffff4444) == 32'h0)
    else $error("reserved bits set");
  a_filter_fields: assert property (ar_mode |=> s_axi_rdata[7:4] == ch3_input_filter
    && s_axi_rdata[15:12] == ch4_input_filter) else $error("filter fields wrong");
  a_drive_off: assert property (ar_en |=> (channel_output_drive_enable
    & ~{s_axi_rdata[12], s_axi_rdata[8], s_axi_rdata[4], s_axi_rdata[0]}) == 4'h0)
    else $error("drive on while disabled");
  a_disabled_low: assert property ((channel_output & ~channel_output_drive_enable)
    == 4'h0) else $error("undriven output not low");
  a_ref_follow: assert property (channel_output_drive_enable[0]
    && $past(channel_output_drive_enable[0]) && !s_axi_bvalid && !$past(s_axi_bvalid)
    |-> (channel_output[0] ^ $past(channel_output[0])) == ($past(channel_reference_output[0])
    ^ $past(channel_reference_output[0], 2))) else $error("output ignores reference");
  a_strobe3_once: assert property (ch3_capture_strobe |=> !ch3_capture_strobe)
    else $error("ch3 strobe too long");
  a_strobe4_once: assert property (ch4_capture_strobe |=> !ch4_capture_strobe)
    else $error("ch4 strobe too long");
  c_enable_read: cover property (ar_en);
  c_ch3_capture: cover property (ch3_capture_strobe);
  c_ch4_capture: cover property (ch4_capture_strobe);
endmodule // ccc_checker

bind ccc_capture_channel_config ccc_checker ccc_checker_i (
  .clk_sys, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .channel_reference_output, .channel_output,
  .channel_output_drive_enable, .ch3_capture_strobe, .ch4_capture_strobe,
  .ch3_input_filter, .ch4_input_filter
);

`default_nettype wire

// *** bench/ccc_pin_model.sv ***
// partner: timer pins and trigger, pulsed on request
`default_nettype none

module ccc_pin_model (
  input  wire logic clk_sys,
  output var  logic filtered_channel_input,
  output var  logic timer_input_three,
  output var  logic timer_input_four,
  output var  logic trigger_select_signal
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] pins = 4'h0;
  // pin order: ch1, three, four, trigger
  assign {trigger_select_signal, timer_input_four, timer_input_three,
          filtered_channel_input} = pins;
  // each level held long enough to be synchronised
  task automatic pulse(input int sel, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      pins[sel] <= 1'b1;
      repeat (8) @(posedge clk_sys);
      pins[sel] <= 1'b0;
      repeat (7) @(posedge clk_sys);
    end
  endtask
endmodule // ccc_pin_model

`default_nettype wire

// *** bench/tb_top.sv ***
// testbench: bus, routing, prescale, capture and output checks
`default_nettype none

`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin n_errors++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, s); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] EN = ccc_pkg::OFS_ENABLE;
  localparam logic [7:0] MD = ccc_pkg::OFS_MODE34;
  logic        clk_sys = 1'b0, sys_rst = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rq;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, s3, s4, fci, ti3, ti4, trg;
  logic [1:0]  bresp, rresp, rsp;
  logic [15:0] cnt = 16'h0;
  logic [3:0]  ref_o = 4'h0, out_o, drv_o, f3, f4;
  int          n_errors = 0, n_checks = 0, n3 = 0, n4 = 0, cyc = 0;

  always #20 clk_sys = ~clk_sys;

  ccc_capture_channel_config ccc_capture_channel_config_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .filtered_channel_input(fci), .timer_input_three(ti3), .timer_input_four(ti4),
    .trigger_select_signal(trg), .counter_value(cnt), .channel_reference_output(ref_o),
    .channel_output(out_o), .channel_output_drive_enable(drv_o), .ch3_capture_strobe(s3),
    .ch4_capture_strobe(s4), .ch3_input_filter(f3), .ch4_input_filter(f4));

  ccc_pin_model ccc_pin_model_i (.clk_sys(clk_sys), .filtered_channel_input(fci),
    .timer_input_three(ti3), .timer_input_four(ti4), .trigger_select_signal(trg));

  // strobe counters and hang guard
  always @(posedge clk_sys) begin
    if (s3) n3++;
    if (s4) n4++;
    cyc++;
    if (cyc == 6000) begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // bus write: bready held until the response
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    awaddr  <= a;
    wdata   <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    rsp = bresp;
  endtask

  // bus read, rready held until data
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    rq  = rdata;
    rsp = rresp;
  endtask

  // output check for an enable word
  task automatic out_chk(input logic [15:0] e, input logic [3:0] r, input logic [7:0] x);
    wr(EN, e);
    ref_o <= r;
    repeat (3) @(posedge clk_sys);
    `CHK("output and drive", x, {out_o, drv_o})
  endtask

  // one ch1 pulse, counter moved at its fall
  task automatic ch1_shot(input logic [15:0] e, input logic [15:0] x);
    wr(EN, e);
    cnt <= 16'h1111;
    fork
      ccc_pin_model_i.pulse(0, 1);
      begin
        wait (fci);
        wait (!fci);
        cnt <= 16'h2222;
      end
    join
    rd(ccc_pkg::OFS_CH1_CAPTURE);
    `CHK("ch1 capture", {16'h0000, x}, rq)
  endtask

  initial begin
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(EN);
    `CHK("enable reset", 32'h0, rq)
    wr(EN, 16'hffff);
    `CHK("write okay", ccc_pkg::RESP_OKAY, rsp)
    rd(EN);
    `CHK("enable bits", 32'h3333, rq)
    rd(8'h00);
    `CHK("unmapped read", {ccc_pkg::RESP_SLVERR, 32'h0}, {rsp, rq})
    out_chk(16'h0001, 4'hf, 8'h11);
    out_chk(16'h0003, 4'hf, 8'h01);
    out_chk(16'h0003, 4'h0, 8'h11);
    out_chk(16'h0000, 4'hf, 8'h00);
    wr(MD, 16'hc931);
    rd(MD);
    `CHK("mode fields", {32'h0000c931, 8'h3c}, {rq, f3, f4})
    // each input select code on each source
    for (int d = 1; d < 4; d++) begin
      wr(EN, 16'h0000);
      wr(MD, {6'h00, d[1:0], 6'h00, d[1:0]});
      wr(EN, 16'h1100);
      for (int p = 1; p < 4; p++) begin
        n3 = 0;
        n4 = 0;
        ccc_pin_model_i.pulse(p, 1);
        `CHK("ch3 source", (p == d) ? 1 : 0, n3)
        `CHK("ch4 source", (p == ((d == 3) ? 3 : 3 - d)) ? 1 : 0, n4)
      end
    end
    wr(MD, 16'h1212);
    rd(MD);
    `CHK("locked select", 32'h1313, rq)
    // each prescale code, eight events
    for (int c = 0; c < 4; c++) begin
      wr(EN, 16'h0000);
      wr(MD, {12'h000, c[1:0], 2'b01});
      wr(EN, 16'h0100);
      n3 = 0;
      ccc_pin_model_i.pulse(1, 8);
      `CHK("prescaled captures", 8 >> c, n3)
    end
    n3 = 0;
    ccc_pin_model_i.pulse(1, 5);
    wr(EN, 16'h0000);
    wr(EN, 16'h0100);
    ccc_pin_model_i.pulse(1, 4);
    `CHK("partial count dropped", 0, n3)
    wr(EN, 16'h0000);
    wr(MD, 16'h0001);
    wr(EN, 16'h0b00);
    n3 = 0;
    ccc_pin_model_i.pulse(1, 2);
    `CHK("both edges", 4, n3)
    wr(ccc_pkg::OFS_CH12_DIR, 16'h0001);
    ch1_shot(16'h0001, 16'h1111);
    ch1_shot(16'h0003, 16'h2222);
    ch1_shot(16'h0000, 16'h2222);
    give_verdict();
  end
endmodule // tb_top

`default_nettype wire
